// *** core/aesb_engine.sv ***
`timescale 1ns/1ps
// aes-128 block engine with byte/word register port
module aesb_engine
	import aesb_pkg::*;
(
	input  wire logic        sys_clk_i,    // system clock
	input  wire logic        reset_n_i,    // async reset, active low
	input  wire logic [3:0]  bus_addr_i,   // register byte offset
	input  wire logic [15:0] bus_wdata_i,  // write data
	input  wire logic        bus_wr_i,     // write strobe
	input  wire logic        bus_rd_i,     // read strobe
	input  wire logic        bus_byte_i,   // byte access when high
	input  wire logic        gie_i,        // processor global irq enable
	output logic      [15:0] bus_rdata_o,  // read data, cycle after strobe
	output logic             irq_o,        // done interrupt request
	output logic             busy_o        // engine running
);

	typedef struct packed {
		aesb_state_t  fsm;
		logic [7:0]   busy_cnt;
		logic [3:0]   round;
		logic [127:0] blk;
		logic [127:0] key;
		logic [127:0] rk;
		logic [3:0]   key_cnt;
		logic [3:0]   din_cnt;
		logic [3:0]   dout_cnt;
		logic         key_loaded;
		logic         din_full;
		logic         dout_read;
		logic         busy;
		logic         done;
		logic         err;
		logic         irq_en;
		logic [1:0]   op;
		logic [15:0]  rdata;
	} aesb_eng_t;

	aesb_eng_t    eng_reg;
	aesb_eng_t    eng_next;
	logic [127:0] rnd_state;
	logic [127:0] rnd_key_fwd;
	logic [127:0] rnd_key_back;
	logic         rnd_dec;
	logic [7:0]   rnd_rcon;

	// round unit steering, backward key steps count down from ten
	assign rnd_dec = (eng_reg.fsm == ST_RND) && eng_reg.op[0];
	assign rnd_rcon = rcon(rnd_dec ? 4'hb - eng_reg.round : eng_reg.round);

	aesb_round u_round (
		.state_i    (eng_reg.blk),
		.rkey_i     (eng_reg.rk),
		.rcon_i     (rnd_rcon),
		.decrypt_i  (rnd_dec),
		.last_i     (eng_reg.round == LAST_ROUND),
		.state_o    (rnd_state),
		.key_fwd_o  (rnd_key_fwd),
		.key_back_o (rnd_key_back)
	);

	// next-state logic for bus access and engine sequencing
	always_comb
	begin
		logic [4:0] adv;
		logic       abort;
		logic       swrst;
		logic       keep_ie;
		logic [1:0] keep_op;
		adv = 5'h00;
		abort = 1'b0;
		swrst = 1'b0;
		keep_ie = 1'b0;
		keep_op = 2'h0;
		eng_next = eng_reg;
		eng_next.rdata = 16'h0000;

		// register writes
		if (bus_wr_i)
		begin
			case (bus_addr_i)
				ADDR_CTRL:
				begin
					eng_next.irq_en = bus_wdata_i[CTRL_IRQEN];
					eng_next.err = bus_wdata_i[CTRL_ERR];
					eng_next.done = bus_wdata_i[CTRL_DONE];
					swrst = bus_wdata_i[CTRL_SWRST];
					if (!eng_reg.busy && bus_wdata_i[1:0] != eng_reg.op)
					begin
						eng_next.op = bus_wdata_i[1:0];
						eng_next.key_loaded = 1'b0;
					end
				end
				ADDR_STAT:
				begin
					if (!eng_reg.busy)
					begin
						eng_next.din_full = bus_wdata_i[STAT_DINWR];
						eng_next.key_loaded = bus_wdata_i[STAT_KEYWR];
					end
				end
				ADDR_KEY:
				begin
					if (eng_reg.busy)
						abort = 1'b1;
					else
					begin
						eng_next.done = 1'b0;
						if (eng_reg.key_loaded && eng_reg.key_cnt == 4'h0)
							eng_next.key_loaded = 1'b0;
						eng_next.key = put_bytes(eng_reg.key, eng_reg.key_cnt, bus_wdata_i, bus_byte_i);
						adv = cnt_adv(eng_reg.key_cnt, bus_byte_i);
						eng_next.key_cnt = adv[3:0];
						if (adv[4])
							eng_next.key_loaded = 1'b1;
					end
				end
				ADDR_DIN:
				begin
					if (eng_reg.busy)
						abort = 1'b1;
					else
					begin
						eng_next.done = 1'b0;
						// input byte n overwrites output byte n in place
						eng_next.blk = put_bytes(eng_reg.blk, eng_reg.din_cnt, bus_wdata_i, bus_byte_i);
						adv = cnt_adv(eng_reg.din_cnt, bus_byte_i);
						eng_next.din_cnt = adv[3:0];
						if (adv[4])
							eng_next.din_full = 1'b1;
					end
				end
				default:
				begin
					eng_next.rdata = 16'h0000;
				end
			endcase
		end

		// register reads, answered on the next edge
		if (bus_rd_i)
		begin
			case (bus_addr_i)
				ADDR_CTRL:
					eng_next.rdata = {3'h0, eng_reg.irq_en, eng_reg.err, 2'h0, eng_reg.done, 6'h00, eng_reg.op};
				ADDR_STAT:
					eng_next.rdata = {eng_reg.dout_cnt, eng_reg.din_cnt, eng_reg.key_cnt, eng_reg.dout_read,
						eng_reg.din_full, eng_reg.key_loaded, eng_reg.busy};
				ADDR_DOUT:
				begin
					eng_next.done = 1'b0;
					if (!eng_reg.busy)
					begin
						eng_next.rdata[7:0] = byte_get(eng_reg.blk, eng_reg.dout_cnt);
						if (!bus_byte_i)
							eng_next.rdata[15:8] = byte_get(eng_reg.blk, eng_reg.dout_cnt + 4'h1);
						adv = cnt_adv(eng_reg.dout_cnt, bus_byte_i);
						eng_next.dout_cnt = adv[3:0];
						if (adv[4])
							eng_next.dout_read = 1'b1;
					end
				end
				default:
					eng_next.rdata = 16'h0000;
			endcase
		end

		// engine sequencing
		case (eng_reg.fsm)
			ST_IDLE:
			begin
				eng_next.rk = eng_next.key;
				eng_next.round = 4'h1;
				if (eng_next.op == OP_KGEN)
				begin
					if (eng_next.key_loaded && !eng_reg.key_loaded)
					begin
						eng_next.fsm = ST_KEXP;
						eng_next.busy = 1'b1;
						eng_next.busy_cnt = KGEN_CYCLES - 8'h01;
					end
				end
				else if (eng_next.din_full && eng_next.key_loaded)
				begin
					eng_next.busy = 1'b1;
					case (eng_next.op)
						OP_ENC:
						begin
							eng_next.fsm = ST_RND;
							eng_next.blk = eng_next.blk ^ eng_next.key;
							eng_next.busy_cnt = ENC_CYCLES - 8'h01;
						end
						OP_DEC:
						begin
							eng_next.fsm = ST_KEXP;
							eng_next.busy_cnt = DEC_CYCLES - 8'h01;
						end
						default:
						begin
							eng_next.fsm = ST_RND;
							eng_next.blk = eng_next.blk ^ eng_next.key;
							eng_next.busy_cnt = DECK_CYCLES - 8'h01;
						end
					endcase
				end
			end
			ST_KEXP:
			begin
				// forward key expansion up to the tenth round key
				eng_next.rk = rnd_key_fwd;
				eng_next.round = eng_reg.round + 4'h1;
				if (eng_reg.round == LAST_ROUND)
				begin
					eng_next.round = 4'h1;
					if (eng_reg.op == OP_KGEN)
					begin
						eng_next.blk = rnd_key_fwd;
						eng_next.key = rnd_key_fwd;
						eng_next.fsm = ST_WAIT;
					end
					else
					begin
						eng_next.blk = eng_reg.blk ^ rnd_key_fwd;
						eng_next.fsm = ST_RND;
					end
				end
			end
			ST_RND:
			begin
				eng_next.blk = rnd_state;
				eng_next.rk = rnd_dec ? rnd_key_back : rnd_key_fwd;
				eng_next.round = eng_reg.round + 4'h1;
				if (eng_reg.round == LAST_ROUND)
					eng_next.fsm = ST_WAIT;
			end
			ST_WAIT:
				eng_next.fsm = ST_WAIT;
			default:
				eng_next.fsm = ST_IDLE;
		endcase

		// busy countdown, completion sets done after any read or write clear, ahead of abort and soft reset
		if (eng_reg.busy)
		begin
			if (eng_reg.busy_cnt == 8'h00)
			begin
				eng_next.busy = 1'b0;
				eng_next.done = 1'b1;
				eng_next.fsm = ST_IDLE;
			end
			else
				eng_next.busy_cnt = eng_reg.busy_cnt - 8'h01;
		end

		// output side held clear while running
		if (eng_next.busy)
		begin
			eng_next.din_full = 1'b0;
			eng_next.dout_read = 1'b0;
			eng_next.dout_cnt = 4'h0;
		end

		// abort and soft reset keep irq enable and operation only
		if (abort || swrst)
		begin
			keep_ie = eng_next.irq_en;
			keep_op = eng_next.op;
			eng_next = '0;
			eng_next.irq_en = keep_ie;
			eng_next.op = keep_op;
			eng_next.err = abort;
		end
	end

	// state register
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			eng_reg <= '0;
		else
			eng_reg <= eng_next;
	end

	assign bus_rdata_o = eng_reg.rdata;
	assign irq_o = eng_reg.done && eng_reg.irq_en && gie_i;
	assign busy_o = eng_reg.busy;

endmodule

// *** core/aesb_pkg.sv ***
// How it works
// - engine computes aes-128 encryption and decryption on 16-byte blocks
// - first byte written is state byte 0, first byte read is output byte 0
// - key, data-in and data-out ports take byte or word accesses
// - while busy, data-out reads zero and output count and full flags stay clear
// - while busy, writes to operation, input-full or key-loaded are ignored
// - key or data-in write while busy aborts, resets engine, sets error flag
// - key and data-in ports are write-only and read as zero
// - input byte n lands where output byte n is read, so interleaving works
// - operation 00 encrypt, 01 decrypt, 10 make decrypt key, 11 decrypt with it
// - any change of the operation clears key-loaded
// - key-loaded sets after 16 key bytes, or software sets it to reuse key
// - first key write after a completed key load clears key-loaded
// - input-full sets after 16 bytes or by software and starts the operation
// - encryption holds busy and takes 167 cycles
// - decryption takes 214 cycles with operation 01 and 167 with 11
// - with operation 10 key generation starts on key-loaded, takes 52 cycles
// - on completion done flag sets, result readable, read-full after 16 bytes
// - done flag clears on data-out read and on key or data-in write
// - another 16 input bytes after reading the result start a new operation
// - setting input-full alone reruns on the previous output block
// - interrupt request when done, done enable and global enable are all set
// - soft reset clears all but done enable and operation, reads as zero
package aesb_pkg;

	// register byte offsets
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [3:0] ADDR_KEY  = 4'h6;
	localparam logic [3:0] ADDR_DIN  = 4'h8;
	localparam logic [3:0] ADDR_DOUT = 4'ha;

	// control register fields
	localparam int CTRL_IRQEN = 12;
	localparam int CTRL_ERR   = 11;
	localparam int CTRL_DONE  = 8;
	localparam int CTRL_SWRST = 7;

	// status register fields
	localparam int STAT_DINWR = 2;
	localparam int STAT_KEYWR = 1;

	// operation encodings
	localparam logic [1:0] OP_ENC  = 2'h0;
	localparam logic [1:0] OP_DEC  = 2'h1;
	localparam logic [1:0] OP_KGEN = 2'h2;
	localparam logic [1:0] OP_DECK = 2'h3;

	// busy durations in clock cycles
	localparam logic [7:0] ENC_CYCLES  = 8'ha7;
	localparam logic [7:0] DEC_CYCLES  = 8'hd6;
	localparam logic [7:0] DECK_CYCLES = 8'ha7;
	localparam logic [7:0] KGEN_CYCLES = 8'h34;

	localparam logic [3:0] LAST_ROUND = 4'ha;

	typedef enum logic [1:0] {ST_IDLE, ST_KEXP, ST_RND, ST_WAIT} aesb_state_t;

	// byte i of a block, byte 0 in the top bits
	function automatic logic [7:0] byte_get(input logic [127:0] b, input logic [3:0] i);
		return b[8*(15-i) +: 8];
	endfunction

	// write one byte or a low/high byte pair into a block
	function automatic logic [127:0] put_bytes(input logic [127:0] b, input logic [3:0] i,
		input logic [15:0] d, input logic is_byte);
		logic [127:0] o;
		logic [3:0]   j;
		o = b;
		j = i + 4'h1;
		o[8*(15-i) +: 8] = d[7:0];
		if (!is_byte)
			o[8*(15-j) +: 8] = d[15:8];
		return o;
	endfunction

	// counter advance, bit 4 marks reaching 16 bytes
	function automatic logic [4:0] cnt_adv(input logic [3:0] c, input logic is_byte);
		return {1'b0, c} + (is_byte ? 5'h01 : 5'h02);
	endfunction

	// round constant for key expansion step k
	function automatic logic [7:0] rcon(input logic [3:0] k);
		case (k)
			4'h1:    return 8'h01;
			4'h2:    return 8'h02;
			4'h3:    return 8'h04;
			4'h4:    return 8'h08;
			4'h5:    return 8'h10;
			4'h6:    return 8'h20;
			4'h7:    return 8'h40;
			4'h8:    return 8'h80;
			4'h9:    return 8'h1b;
			4'ha:    return 8'h36;
			default: return 8'h00;
		endcase
	endfunction

endpackage

// *** core/aesb_round.sv ***
`timescale 1ns/1ps
// one aes round, forward and backward key step, purely combinational
module aesb_round
	import aesb_pkg::*;
(
	input  wire logic [127:0] state_i,    // current state
	input  wire logic [127:0] rkey_i,     // current round key
	input  wire logic [7:0]   rcon_i,     // round constant
	input  wire logic         decrypt_i,  // inverse round when high
	input  wire logic         last_i,     // final round, no column mix
	output logic      [127:0] state_o,    // state after the round
	output logic      [127:0] key_fwd_o,  // next round key
	output logic      [127:0] key_back_o  // previous round key
);

	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++)
		begin
			if (b[i])
				p = p ^ x;
			x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1b : 8'h00);
		end
		return p;
	endfunction

	// field inverse as a to the power 254
	function automatic logic [7:0] ginv(input logic [7:0] a);
		logic [7:0] p;
		logic [7:0] q;
		p = a;
		q = 8'h01;
		for (int k = 1; k < 8; k++)
		begin
			p = gmul(p, p);
			q = gmul(q, p);
		end
		return q;
	endfunction

	function automatic logic [7:0] rotl(input logic [7:0] b, input int n);
		return (b << n) | (b >> (8 - n));
	endfunction

	function automatic logic [7:0] sbox(input logic [7:0] a);
		logic [7:0] v;
		v = ginv(a);
		return v ^ rotl(v, 1) ^ rotl(v, 2) ^ rotl(v, 3) ^ rotl(v, 4) ^ 8'h63;
	endfunction

	function automatic logic [7:0] isbox(input logic [7:0] b);
		return ginv(rotl(b, 1) ^ rotl(b, 3) ^ rotl(b, 6) ^ 8'h05);
	endfunction

	// column mix, forward uses 2 3 1 1 and inverse 14 11 13 9
	function automatic logic [31:0] mixcol(input logic [31:0] c, input logic inv);
		logic [7:0] m0, m1, m2, m3;
		m0 = inv ? 8'h0e : 8'h02;
		m1 = inv ? 8'h0b : 8'h03;
		m2 = inv ? 8'h0d : 8'h01;
		m3 = inv ? 8'h09 : 8'h01;
		return {gmul(c[31:24], m0) ^ gmul(c[23:16], m1) ^ gmul(c[15:8], m2) ^ gmul(c[7:0], m3),
			gmul(c[31:24], m3) ^ gmul(c[23:16], m0) ^ gmul(c[15:8], m1) ^ gmul(c[7:0], m2),
			gmul(c[31:24], m2) ^ gmul(c[23:16], m3) ^ gmul(c[15:8], m0) ^ gmul(c[7:0], m1),
			gmul(c[31:24], m1) ^ gmul(c[23:16], m2) ^ gmul(c[15:8], m3) ^ gmul(c[7:0], m0)};
	endfunction

	function automatic logic [31:0] subrot(input logic [31:0] w, input logic [7:0] rc);
		return {sbox(w[23:16]) ^ rc, sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
	endfunction

	// shifted and substituted state, then column mix and key add, key add before column mix when decrypting
	always_comb
	begin
		logic [127:0] sr;
		logic [127:0] mx;
		logic [31:0]  w0, w1, w2, w3, p0, p1, p2, p3;
		sr = '0;
		mx = '0;
		w0 = rkey_i[127:96];
		w1 = rkey_i[95:64];
		w2 = rkey_i[63:32];
		w3 = rkey_i[31:0];
		p0 = w0 ^ subrot(w3, rcon_i);
		p1 = w1 ^ p0;
		p2 = w2 ^ p1;
		p3 = w3 ^ p2;
		for (int c = 0; c < 4; c++)
		begin
			for (int r = 0; r < 4; r++)
			begin
				if (decrypt_i)
					sr[8*(15-4*c-r) +: 8] = isbox(state_i[8*(15-4*((c-r)&3)-r) +: 8]);
				else
					sr[8*(15-4*c-r) +: 8] = sbox(state_i[8*(15-4*((c+r)&3)-r) +: 8]);
			end
		end
		key_fwd_o = {p0, p1, p2, p3};
		key_back_o = {w0 ^ subrot(w3 ^ w2, rcon_i), w1 ^ w0, w2 ^ w1, w3 ^ w2};
		mx = decrypt_i ? sr ^ key_back_o : sr;
		if (!last_i)
		begin
			for (int c = 0; c < 4; c++)
				mx[32*(3-c) +: 32] = mixcol(mx[32*(3-c) +: 32], decrypt_i);
		end
		state_o = decrypt_i ? mx : mx ^ key_fwd_o;
	end

endmodule

// *** tb/aesb_engine_asserts.sv ***
`timescale 1ns/1ps
// port checker for the block engine
module aesb_chk
	import aesb_pkg::*;
(
	input wire logic        sys_clk_i,    // clock
	input wire logic        reset_n_i,    // reset
	input wire logic [3:0]  bus_addr_i,   // offset
	input wire logic [15:0] bus_wdata_i,  // write data
	input wire logic        bus_wr_i,     // write strobe
	input wire logic        bus_rd_i,     // read strobe
	input wire logic        bus_byte_i,   // byte access
	input wire logic        gie_i,        // global enable
	input wire logic [15:0] bus_rdata_o,  // read data
	input wire logic        irq_o,        // interrupt
	input wire logic        busy_o        // busy
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [7:0] cnt_reg;
	logic       ab_reg;
	// decoded accesses
	wire dat_wr = bus_wr_i && (bus_addr_i == ADDR_KEY || bus_addr_i == ADDR_DIN);
	wire rst_wr = bus_wr_i && bus_addr_i == ADDR_CTRL && bus_wdata_i[CTRL_SWRST];
	wire wo_rd  = bus_rd_i && (bus_addr_i == ADDR_KEY || bus_addr_i == ADDR_DIN);
	wire ctl_wr = bus_wr_i && bus_addr_i == ADDR_CTRL;
	// busy run length and whether it was cut short
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cnt_reg <= 8'h00;
			ab_reg  <= 1'b0;
		end
		else
		begin
			cnt_reg <= busy_o ? cnt_reg + 8'h01 : 8'h00;
			ab_reg  <= busy_o && (ab_reg || dat_wr || rst_wr);
		end
	end
	sequence s_abort;
		busy_o && dat_wr;
	endsequence
	sequence s_dout_rd;
		bus_rd_i && bus_addr_i == ADDR_DOUT;
	endsequence
	a_wo_zero: assert property (wo_rd |=> bus_rdata_o == 16'h0000)
		else $error("write-only port read nonzero");
	a_dout_busy: assert property (s_dout_rd ##0 busy_o |=> bus_rdata_o == 16'h0000)
		else $error("data-out read nonzero while busy");
	a_stat_busy: assert property (bus_rd_i && bus_addr_i == ADDR_STAT && busy_o
		|=> (bus_rdata_o & 16'hf00d) == 16'h0001) else $error("status flags not held while busy");
	a_abort_stop: assert property (s_abort |=> !busy_o)
		else $error("abort write did not stop engine");
	a_swrst_stop: assert property (rst_wr |=> !busy_o)
		else $error("soft reset did not stop engine");
	a_irq_gate: assert property (!gie_i |-> !irq_o)
		else $error("irq without global enable");
	// a request only rises at completion, at global enable or after a control write
	a_irq_cause: assert property ($rose(irq_o) |-> $fell(busy_o) || $rose(gie_i) || $past(ctl_wr))
		else $error("irq rose without a cause");
	a_rd_clr: assert property (s_dout_rd ##0 !busy_o |=> !irq_o)
		else $error("done not cleared by data-out read");
	a_wr_clr: assert property (dat_wr && !busy_o |=> !irq_o)
		else $error("done not cleared by port write");
	a_busy_len: assert property ($fell(busy_o) && !ab_reg |->
		cnt_reg == ENC_CYCLES || cnt_reg == DEC_CYCLES || cnt_reg == KGEN_CYCLES)
		else $error("busy run length wrong");
endmodule

bind aesb_engine aesb_chk u_chk (.sys_clk_i, .reset_n_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i, .bus_rd_i,
	.bus_byte_i, .gie_i, .bus_rdata_o, .irq_o, .busy_o);

// *** tb/aesb_engine_tb.sv ***
`timescale 1ns/1ps
// self-checking bench, host model drives the register port
module aesb_engine_tb
	import aesb_pkg::*;
();
	localparam logic [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
	localparam logic [127:0] PT  = 128'h00112233445566778899aabbccddeeff;
	localparam logic [127:0] CT  = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
	localparam logic [127:0] RK  = 128'h13111d7fe3944a17f307a78b4d2b30c5;
	logic        sys_clk;
	logic        reset_n;
	logic        gie;
	logic [3:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        wr;
	logic        rd;
	logic        bsel;
	logic        irq;
	logic        busy;
	int          failures;
	int          n_tests;
	int          bc = 0;
	int          cyc = 0;

	aesb_engine u_dut (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .bus_addr_i(addr), .bus_wdata_i(wdata),
		.bus_wr_i(wr), .bus_rd_i(rd), .bus_byte_i(bsel), .gie_i(gie), .bus_rdata_o(rdata),
		.irq_o(irq), .busy_o(busy));
	aesb_host u_h (.clk_i(sys_clk), .rd_i(rdata), .addr_o(addr), .wd_o(wdata), .wr_o(wr), .rd_o(rd),
		.byte_o(bsel));

	// 250 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// busy cycle count and run limit
	always @(posedge sys_clk)
	begin
		bc <= busy ? bc + 1 : 0;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			failures = failures + 1;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("wrong value %s exp %h got %h", n, e, g);
			failures++;
		end
	endtask
	// register read and compare
	task automatic rc(input logic [3:0] a, input logic [15:0] e, input string n);
		logic [15:0] q;
		u_h.rd(a, 1'b0, q);
		chk(n, e, q);
	endtask
	// watch one operation: busy reads, length, interrupt, result
	task automatic run(input int n, input logic [127:0] e, input logic b, input logic ie);
		logic [15:0]  q;
		logic [127:0] v;
		for (int k = 0; k < 50 && busy !== 1'b1; k++)
			@(posedge sys_clk) #1;
		rc(ADDR_DOUT, 16'h0000, "dout busy");
		u_h.rd(ADDR_STAT, 1'b0, q);
		chk("stat busy", 16'h0001, q & 16'hf00d);
		for (int k = 0; k < 300 && busy !== 1'b0; k++)
			@(posedge sys_clk) #1;
		chk("busy len", n, bc);
		chk("irq done", ie, irq);
		@(posedge sys_clk);
		gie <= 1'b0;
		#1 chk("irq gie", 0, irq);
		@(posedge sys_clk);
		gie <= 1'b1;
		u_h.rb(b, v);
		chk("result", e, v);
		chk("irq read", 0, irq);
	endtask
	task automatic t_reset();
		rc(ADDR_CTRL, 16'h0000, "ctrl");
		rc(ADDR_STAT, 16'h0000, "stat");
		rc(ADDR_KEY, 16'h0000, "key rd");
		rc(ADDR_DIN, 16'h0000, "din rd");
		rc(4'h2, 16'h0000, "unmapped");
	endtask
	task automatic t_enc();
		u_h.wr(ADDR_CTRL, 16'h1000, 1'b0);
		u_h.ld(ADDR_KEY, KEY, 1'b0);
		rc(ADDR_STAT, 16'h0002, "stat key");
		u_h.ld(ADDR_DIN, PT, 1'b0);
		run(167, CT, 1'b0, 1'b1);
		rc(ADDR_STAT, 16'h000a, "stat done");
	endtask
	task automatic t_dec();
		u_h.wr(ADDR_CTRL, 16'h1001, 1'b0);
		u_h.ld(ADDR_KEY, KEY, 1'b1);
		u_h.ld(ADDR_DIN, CT, 1'b1);
		run(214, PT, 1'b1, 1'b1);
		u_h.ld(ADDR_DIN, CT, 1'b0);
		run(214, PT, 1'b0, 1'b1);
	endtask
	task automatic t_ofb();
		logic [15:0] q;
		u_h.wr(ADDR_CTRL, 16'h1000, 1'b0);
		u_h.rd(ADDR_STAT, 1'b0, q);
		chk("key flag", 0, q[1]);
		u_h.wr(ADDR_STAT, 16'h0006, 1'b0);
		run(167, CT, 1'b0, 1'b1);
	endtask
	task automatic t_kgen();
		u_h.wr(ADDR_CTRL, 16'h0002, 1'b0);
		u_h.ld(ADDR_KEY, KEY, 1'b0);
		run(52, RK, 1'b0, 1'b0);
		u_h.wr(ADDR_CTRL, 16'h0003, 1'b0);
		u_h.wr(ADDR_STAT, 16'h0002, 1'b0);
		u_h.ld(ADDR_DIN, CT, 1'b0);
		run(167, PT, 1'b0, 1'b0);
	endtask
	task automatic t_abort();
		u_h.wr(ADDR_CTRL, 16'h1000, 1'b0);
		u_h.wr(ADDR_STAT, 16'h0006, 1'b0);
		for (int k = 0; k < 50 && busy !== 1'b1; k++)
			@(posedge sys_clk) #1;
		u_h.wr(ADDR_CTRL, 16'h1001, 1'b0);
		u_h.wr(ADDR_STAT, 16'h0000, 1'b0);
		rc(ADDR_STAT, 16'h0003, "stat keep");
		u_h.wr(ADDR_DIN, 16'h1234, 1'b0);
		#1 chk("busy abort", 0, busy);
		rc(ADDR_CTRL, 16'h1800, "ctrl err");
		rc(ADDR_STAT, 16'h0000, "stat err");
		u_h.wr(ADDR_CTRL, 16'h1000, 1'b0);
		rc(ADDR_CTRL, 16'h1000, "err clr");
	endtask
	task automatic t_swrst();
		u_h.wr(ADDR_STAT, 16'h0006, 1'b0);
		u_h.wr(ADDR_CTRL, 16'h1080, 1'b0);
		#1 chk("busy swrst", 0, busy);
		u_h.wr(ADDR_STAT, 16'h0002, 1'b0);
		for (int i = 0; i < 3; i++)
			u_h.wr(ADDR_KEY, 16'h00aa, 1'b1);
		u_h.wr(ADDR_KEY, 16'hbbcc, 1'b0);
		rc(ADDR_STAT, 16'h0050, "key cnt");
		u_h.wr(ADDR_CTRL, 16'h1083, 1'b0);
		rc(ADDR_CTRL, 16'h1003, "ctrl swrst");
		rc(ADDR_STAT, 16'h0000, "stat swrst");
	endtask
	// main sequence
	initial
	begin
		failures = 0;
		n_tests = 0;
		gie = 1'b1;
		reset_n = 1'b0;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_reset();
		t_enc();
		t_dec();
		t_ofb();
		t_kgen();
		t_abort();
		t_swrst();
		end_sim();
	end
endmodule

// *** tb/aesb_host.sv ***
`timescale 1ns/1ps
// host bus master, strobes one cycle, data lines inverted once released
module aesb_host
	import aesb_pkg::*;
(
	input  wire logic        clk_i,   // system clock
	input  wire logic [15:0] rd_i,    // read data
	output logic      [3:0]  addr_o,  // byte offset
	output logic      [15:0] wd_o,    // write data
	output logic             wr_o,    // write strobe
	output logic             rd_o,    // read strobe
	output logic             byte_o   // byte access
);
	// idle bus at time zero
	initial
	begin
		addr_o = 4'h0;
		wd_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
		byte_o = 1'b0;
	end
	// one write cycle
	task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic b);
		@(posedge clk_i);
		addr_o <= a;
		wd_o <= d;
		byte_o <= b;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wd_o <= ~d;
	endtask
	// one read cycle, data taken in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic b, output logic [15:0] q);
		@(posedge clk_i);
		addr_o <= a;
		byte_o <= b;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1 q = rd_i;
	endtask
	// whole block, one width for the whole transfer, earlier byte in the low half of each word
	task automatic ld(input logic [3:0] a, input logic [127:0] v, input logic b);
		logic [135:0] w;
		w = {v, 8'h00};
		for (int i = 0; i < 16; i += b ? 1 : 2)
			wr(a, {w[127-8*i -: 8], w[135-8*i -: 8]}, b);
	endtask
	// read a whole result block
	task automatic rb(input logic b, output logic [127:0] v);
		logic [15:0] q;
		for (int i = 0; i < 16; i += b ? 1 : 2)
		begin
			rd(ADDR_DOUT, b, q);
			v[127-8*i -: 8] = q[7:0];
			if (!b)
				v[119-8*i -: 8] = q[15:8];
		end
	endtask
endmodule
